//--- hbsg_pkg.sv
package hbsg_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 64;
  localparam int CLK_REG_COUNT = 14;
  localparam int USER_RAM_COUNT = 50;
  localparam logic [ADDR_W-1:0] INT_LO_ADDR = 17'h00000;
  localparam logic [ADDR_W-1:0] INT_HI_ADDR = 17'h0003F;
  localparam logic [DATA_W-1:0] REG_RST_VAL = 8'h00;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PWR_HOLD_MS = 150;
  localparam int PWR_HOLD_CYC = PWR_HOLD_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic chipEn_n;
    logic outEn_n;
    logic writeEn_n;
    logic [ADDR_W-1:0] addr;
  } hbsg_bus_t;

  typedef struct packed {
    logic ramChipSelect_n;
    logic ramReadGate_n;
  } hbsg_ram_t;
endpackage

//--- hbsg_sync.sv
`timescale 1ns/1ns
module hbsg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // Two flop synchroniser
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
    end
    else
    begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule // hbsg_sync

//--- hbsg_host_bus_sram_gating.sv
`timescale 1ns/1ns
module hbsg_host_bus_sram_gating #(
  parameter int HOLD_CYC = hbsg_pkg::PWR_HOLD_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host bus pins
  input wire hbsg_pkg::hbsg_bus_t hostBus,
  input wire logic [hbsg_pkg::DATA_W-1:0] hostDataIn,
  output logic [hbsg_pkg::DATA_W-1:0] hostDataOut,
  output logic hostDataOe,
  // Supply sensing, high while supply at or above power_fail_threshold
  input wire logic supplyGood,
  // External RAM
  output hbsg_pkg::hbsg_ram_t ramCtrl,
  output logic powerFail_n
);
  import hbsg_pkg::*;

  localparam int BUS_W = $bits(hbsg_bus_t);
  localparam int CNT_W = $clog2(HOLD_CYC + 1);
  localparam int SYNC_W = BUS_W + DATA_W + 1;
  // Strobes idle high through reset, no false write window
  localparam logic [SYNC_W-1:0] SYNC_RST = {3'h7, {(SYNC_W - 3){1'b0}}};

  typedef enum logic [2:0] {
    ST_FAIL = 3'b001,
    ST_HOLD = 3'b010,
    ST_GOOD = 3'b100
  } hbsg_pwr_t;

  hbsg_bus_t busS;
  logic [DATA_W-1:0] dataS;
  logic supplyS;
  logic [DATA_W-1:0] regFile [REG_COUNT];
  hbsg_pwr_t pwrState_ff;
  hbsg_pwr_t nxt_pwrState;
  logic [CNT_W-1:0] holdCnt_ff;
  logic writeAct_ff;
  logic [DATA_W-1:0] dataOut_ff;
  logic powerOk;
  logic isInternal;
  logic writeAct;
  logic writeEnd;
  logic readInt;
  logic readValid_ff;
  logic [CNT_W-1:0] upCnt_ff;

  function automatic logic in_internal(input logic [ADDR_W-1:0] a);
    return (a >= INT_LO_ADDR) && (a <= INT_HI_ADDR);
  endfunction

  hbsg_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .clock(clock),
    .rst(rst),
    .asyncIn({hostBus, hostDataIn, supplyGood}),
    .syncOut({busS, dataS, supplyS})
  );

  // Power sequencing
  always_comb
  begin
    nxt_pwrState = pwrState_ff;
    case (pwrState_ff)
      ST_FAIL: if (supplyS) nxt_pwrState = ST_HOLD;
      ST_HOLD:
      begin
        if (!supplyS)
          nxt_pwrState = ST_FAIL;
        else if (holdCnt_ff >= CNT_W'(HOLD_CYC - 1))
          nxt_pwrState = ST_GOOD;
      end
      ST_GOOD: if (!supplyS) nxt_pwrState = ST_FAIL;
      default: nxt_pwrState = ST_FAIL;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pwrState_ff <= ST_FAIL;
    else
      pwrState_ff <= nxt_pwrState;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      holdCnt_ff <= '0;
    else if (pwrState_ff == ST_HOLD)
      holdCnt_ff <= holdCnt_ff + CNT_W'(1);
    else
      holdCnt_ff <= '0;
  end

  // Supply good cycles while still blocked
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      upCnt_ff <= '0;
    else if (powerOk || !supplyS)
      upCnt_ff <= '0;
    else if (upCnt_ff != '1)
      upCnt_ff <= upCnt_ff + CNT_W'(1);
  end

  assign powerOk = (pwrState_ff == ST_GOOD);
  assign powerFail_n = powerOk;

  // Address decode, 17 bit flat map with internal overlay
  assign isInternal = in_internal(hostBus.addr);

  // RAM gating is combinational pass through from host pins
  always_comb
  begin
    ramCtrl.ramChipSelect_n = powerOk ? hostBus.chipEn_n : 1'b1;
    ramCtrl.ramReadGate_n = 1'b1;
    if (powerOk && !hostBus.chipEn_n && !isInternal)
      ramCtrl.ramReadGate_n = hostBus.outEn_n;
  end

  // Write window tracking on synchronised strobes
  assign writeAct = !busS.chipEn_n && !busS.writeEn_n;
  assign writeEnd = writeAct_ff && !writeAct;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      writeAct_ff <= 1'b0;
    else
      writeAct_ff <= writeAct;
  end

  // Internal register file, written at end of write window
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regFile[i] <= REG_RST_VAL;
    end
    else if (writeEnd && powerOk && in_internal(busS.addr))
      regFile[busS.addr[5:0]] <= dataS;
  end

  assign readInt = powerOk && !busS.chipEn_n && busS.writeEn_n && !busS.outEn_n
                   && in_internal(busS.addr);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dataOut_ff <= REG_RST_VAL;
    else if (readInt)
      dataOut_ff <= regFile[busS.addr[5:0]];
  end

  // Read data valid the cycle after a load, readInt delayed by one cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      readValid_ff <= 1'b0;
    else
      readValid_ff <= readInt;
  end

  assign hostDataOut = dataOut_ff;
  // Drivers on only for internal reads
  assign hostDataOe = readValid_ff && readInt && !hostBus.outEn_n && !hostBus.chipEn_n
                      && hostBus.writeEn_n && isInternal;

  // Assertions
  property p_read_gate_internal;
    @(posedge clock) disable iff (rst)
    isInternal |-> ramCtrl.ramReadGate_n;
  endproperty
  a_read_gate_internal: assert property (p_read_gate_internal)
    else $error("RAM read gate active on internal address");
  property p_read_gate_pass;
    @(posedge clock) disable iff (rst)
    (powerOk && !hostBus.chipEn_n && !isInternal) |-> ramCtrl.ramReadGate_n == hostBus.outEn_n;
  endproperty
  a_read_gate_pass: assert property (p_read_gate_pass)
    else $error("RAM read gate not following output enable");
  property p_cs_block;
    @(posedge clock) disable iff (rst)
    !powerOk |-> ramCtrl.ramChipSelect_n;
  endproperty
  a_cs_block: assert property (p_cs_block)
    else $error("RAM chip select active while power bad");
  property p_cs_pass;
    @(posedge clock) disable iff (rst)
    powerOk |-> ramCtrl.ramChipSelect_n == hostBus.chipEn_n;
  endproperty
  a_cs_pass: assert property (p_cs_pass)
    else $error("RAM chip select not following chip enable");
  property p_gate_power;
    @(posedge clock) disable iff (rst)
    (!powerOk || hostBus.chipEn_n) |-> ramCtrl.ramReadGate_n;
  endproperty
  a_gate_power: assert property (p_gate_power)
    else $error("RAM read gate active without power or select");
  property p_pf_low;
    @(posedge clock) disable iff (rst)
    !supplyS |=> !powerFail_n;
  endproperty
  a_pf_low: assert property (p_pf_low)
    else $error("Power fail released while supply low");
  property p_hold;
    @(posedge clock) disable iff (rst)
    (pwrState_ff == ST_FAIL && supplyS) |=> !powerOk [*2];
  endproperty
  a_hold: assert property (p_hold)
    else $error("Recovery hold skipped");
  property p_write;
    @(posedge clock) disable iff (rst)
    (writeEnd && powerOk && in_internal(busS.addr))
      |=> regFile[$past(busS.addr[5:0])] == $past(dataS);
  endproperty
  a_write: assert property (p_write)
    else $error("Internal write not stored");
  property p_no_drive;
    @(posedge clock) disable iff (rst)
    (!hostBus.writeEn_n || !isInternal || hostBus.outEn_n) |-> !hostDataOe;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("Data driven during write or external access");
  property p_read_data;
    @(posedge clock) disable iff (rst)
    hostDataOe |-> hostDataOut == $past(regFile[busS.addr[5:0]]) || $past(writeEnd);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("Read data mismatch");

  // Protection and decode checks
  property p_write_refused;
    @(posedge clock) disable iff (rst)
    (writeEnd && !in_internal(busS.addr))
      |=> regFile[$past(busS.addr[5:0])] == $past(regFile[busS.addr[5:0]]);
  endproperty
  a_write_refused: assert property (p_write_refused)
    else $error("Register written by external address");
  property p_write_protect;
    @(posedge clock) disable iff (rst)
    (writeEnd && !powerOk)
      |=> regFile[$past(busS.addr[5:0])] == $past(regFile[busS.addr[5:0]]);
  endproperty
  a_write_protect: assert property (p_write_protect)
    else $error("Register written while power bad");
  property p_out_hold;
    @(posedge clock) disable iff (rst)
    !readInt |=> $stable(hostDataOut);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("Read data changed without a read");
  property p_oe_needs_ce;
    @(posedge clock) disable iff (rst)
    hostBus.chipEn_n |-> !hostDataOe;
  endproperty
  a_oe_needs_ce: assert property (p_oe_needs_ce)
    else $error("Data driven without chip enable");
  property p_gate_clock_regs;
    @(posedge clock) disable iff (rst)
    (hostBus.addr < ADDR_W'(CLK_REG_COUNT)) |-> ramCtrl.ramReadGate_n;
  endproperty
  a_gate_clock_regs: assert property (p_gate_clock_regs)
    else $error("RAM read gate active on clock register");
  property p_hold_len;
    @(posedge clock) disable iff (rst)
    $rose(powerOk) |-> upCnt_ff >= CNT_W'(HOLD_CYC);
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("Recovery hold shorter than required");
  property p_read_power;
    @(posedge clock) disable iff (rst)
    !powerOk |-> !hostDataOe;
  endproperty
  a_read_power: assert property (p_read_power)
    else $error("Data driven while power bad");
  property p_cs_fail;
    @(posedge clock) disable iff (rst)
    !supplyS |=> ramCtrl.ramChipSelect_n;
  endproperty
  a_cs_fail: assert property (p_cs_fail)
    else $error("RAM chip select not blocked after supply loss");

  c_int_read: cover property (@(posedge clock) disable iff (rst) hostDataOe);
  c_write_refused: cover property (@(posedge clock) disable iff (rst) writeEnd && !powerOk);
  c_int_write: cover property (@(posedge clock) disable iff (rst) writeEnd && powerOk);
  c_ext_read: cover property (@(posedge clock) disable iff (rst) !ramCtrl.ramReadGate_n);
  c_recover: cover property (@(posedge clock) disable iff (rst) $rose(powerOk));
endmodule // hbsg_host_bus_sram_gating

//--- hbsg_ram_model.sv
`timescale 1ns/1ns
module hbsg_ram_model (
  // Control from block
  input wire hbsg_pkg::hbsg_ram_t ramCtrl,
  input wire logic [hbsg_pkg::ADDR_W-1:0] addr,
  // Read data toward host bus
  output logic [hbsg_pkg::DATA_W-1:0] ramQ,
  output logic ramOe
);
  import hbsg_pkg::*;
  logic [DATA_W-1:0] lastQ;
  assign ramOe = !ramCtrl.ramChipSelect_n && !ramCtrl.ramReadGate_n;
  // Remember last driven byte
  always @(addr or ramOe)
  begin
    if (ramOe)
      lastQ = addr[7:0] ^ 8'h3C;
  end
  // Released bus shows inverse of last value
  assign ramQ = ramOe ? (addr[7:0] ^ 8'h3C) : ~lastQ;
endmodule // hbsg_ram_model

//--- hbsg_host_bus_sram_gating_bench.sv
`timescale 1ns/1ns
module hbsg_host_bus_sram_gating_bench;
  import hbsg_pkg::*;
  localparam int HOLD = 10;
  logic clock = 1'b0;
  logic rst = 1'b1;
  hbsg_bus_t hostBus = '{1'b1, 1'b1, 1'b1, 17'h00000};
  logic [7:0] hostDrive = 8'h00;
  logic supplyGood = 1'b0;
  logic [7:0] hostDataOut, ramQ, busData;
  logic hostDataOe, ramOe, powerFail_n;
  hbsg_ram_t ramCtrl;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  assign busData = hostDataOe ? hostDataOut : (ramOe ? ramQ : hostDrive);
  hbsg_host_bus_sram_gating #(.HOLD_CYC(HOLD)) dut (.clock(clock), .rst(rst),
    .hostBus(hostBus), .hostDataIn(busData), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .supplyGood(supplyGood), .ramCtrl(ramCtrl),
    .powerFail_n(powerFail_n));
  hbsg_ram_model ram (.ramCtrl(ramCtrl), .addr(hostBus.addr), .ramQ(ramQ), .ramOe(ramOe));
  task automatic finish_test();
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Host changes strobes, address and data together just after a rising clock edge
  task automatic drive(input logic ce, oe, we, input logic [16:0] a, input logic [7:0] d);
    @(posedge clock);
    hostBus <= '{ce, oe, we, a};
    hostDrive <= d;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic powerUp();
    int n;
    n = 0;
    drive(1'b0, 1'b1, 1'b1, 17'h00040, 8'h00);
    settle(2);
    chk("csBad", 17'h1, ramCtrl.ramChipSelect_n);
    @(posedge clock) supplyGood <= 1'b1;
    settle(HOLD / 2);
    chk("csHold", 17'h1, ramCtrl.ramChipSelect_n);
    chk("pfHold", 17'h0, powerFail_n);
    while (powerFail_n !== 1'b1 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    chk("holdLen", 17'(HOLD + 3 - HOLD / 2), 17'(n));
    chk("pfUp", 17'h1, powerFail_n);
    chk("csGood", 17'h0, ramCtrl.ramChipSelect_n);
  endtask
  task automatic regRw();
    logic [16:0] a[4] = '{17'h00000, 17'h0000D, 17'h0000E, 17'h0003F};
    foreach (a[i])
    begin
      drive(1'b0, 1'b1, 1'b0, a[i], 8'hA5 ^ a[i][7:0]);
      settle(4);
      chk("oeWrite", 17'h0, hostDataOe);
      drive(1'(i % 2), 1'b1, 1'(1 - i % 2), a[i], 8'hA5 ^ a[i][7:0]);
      settle(4);
      drive(1'b1, 1'b1, 1'b1, a[i], 8'h00);
      settle(2);
    end
    foreach (a[i])
    begin
      drive(1'b0, 1'b0, 1'b1, a[i], 8'h00);
      settle(5);
      chk("rdData", {9'h0, 8'hA5 ^ a[i][7:0]}, busData);
      chk("rdOe", 17'h1, hostDataOe);
      chk("gateInt", 17'h1, ramCtrl.ramReadGate_n);
      drive(1'b0, 1'b1, 1'b1, a[i], 8'h00);
      settle(1);
      chk("oeOff", 17'h0, hostDataOe);
    end
  endtask
  task automatic extAcc();
    logic [16:0] a[2] = '{17'h00040, 17'h1FFFF};
    foreach (a[i])
    begin
      drive(1'b0, 1'b0, 1'b1, a[i], 8'h00);
      settle(1);
      chk("gateExt", 17'h0, ramCtrl.ramReadGate_n);
      chk("extData", {9'h0, a[i][7:0] ^ 8'h3C}, busData);
      chk("oeExt", 17'h0, hostDataOe);
      drive(1'b1, 1'b0, 1'b1, a[i], 8'h00);
      settle(1);
      chk("gateNoCe", 17'h1, ramCtrl.ramReadGate_n);
    end
    drive(1'b0, 1'b1, 1'b0, 17'h00040, 8'h5A);
    settle(4);
    drive(1'b1, 1'b1, 1'b1, 17'h00040, 8'h5A);
    settle(3);
    drive(1'b0, 1'b0, 1'b1, 17'h00000, 8'h00);
    settle(5);
    chk("noAlias", 17'hA5, hostDataOut);
  endtask
  task automatic powerLoss();
    drive(1'b0, 1'b0, 1'b1, 17'h00040, 8'h00);
    @(posedge clock) supplyGood <= 1'b0;
    settle(4);
    chk("csLoss", 17'h1, ramCtrl.ramChipSelect_n);
    chk("gateLoss", 17'h1, ramCtrl.ramReadGate_n);
    chk("pfLoss", 17'h0, powerFail_n);
    drive(1'b0, 1'b1, 1'b0, 17'h0000D, 8'h77);
    settle(4);
    drive(1'b1, 1'b1, 1'b1, 17'h0000D, 8'h77);
    settle(3);
    drive(1'b0, 1'b0, 1'b1, 17'h00000, 8'h00);
    settle(5);
    chk("oeLoss", 17'h0, hostDataOe);
    @(posedge clock) supplyGood <= 1'b1;
    settle(HOLD + 4);
    drive(1'b0, 1'b0, 1'b1, 17'h0000D, 8'h00);
    settle(5);
    chk("wrProt", {9'h0, 8'hA5 ^ 8'h0D}, busData);
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    powerUp();
    regRw();
    extAcc();
    powerLoss();
    finish_test();
  end
endmodule // hbsg_host_bus_sram_gating_bench
